// file: etwsf_fifo.sv
// shift-style fifo, head entry is a register so out_valid and out_data come from flops
`timescale 1ns/1ps
module etwsf_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 4
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [CW-1:0]    count_r;
    logic [CW-1:0]    count_nxt;
    logic             valid_r;
    logic             pop;
    logic             push;
    logic [CW-1:0]    slot;

    if (DEPTH < 2 || WIDTH < 1) begin : g_bad_cfg
        $error("etwsf_fifo: DEPTH must be at least 2 and WIDTH at least 1");
    end

    assign pop       = out_valid && out_ready;
    assign in_ready  = (count_r != CW'(DEPTH)) || pop;
    assign push      = in_valid && in_ready;
    assign slot      = pop ? count_r - CW'(1) : count_r;
    assign count_nxt = count_r + CW'(push) - CW'(pop);
    // valid kept in its own flop so the output comes straight from a register
    assign out_valid = valid_r;
    assign out_data  = mem_r[0];

    always_ff @(posedge clk) begin
        if (rst) begin
            count_r <= '0;
            valid_r <= 1'b0;
        end else begin
            count_r <= count_nxt;
            valid_r <= (count_nxt != '0);
        end
    end

    for (genvar i = 0; i < DEPTH; i++) begin : g_cell
        always_ff @(posedge clk) begin
            if (rst) begin
                mem_r[i] <= '0;
            end else if (push && slot == CW'(i)) begin
                mem_r[i] <= in_data;
            end else if (pop && i < DEPTH - 1) begin
                mem_r[i] <= mem_r[(i + 1) % DEPTH];
            end
        end
    end
endmodule : etwsf_fifo

// file: etwsf_front.sv
// bus-facing front end of a two-wire serial eeprom slave
// Operation
// [R1] 1k/2k: slave address from three straps, eight devices per bus.
// [R2] 4k: two upper straps only, four devices per bus.
// [R3] 8k: highest strap only, two devices per bus.
// [R4] selected only when strapped address equals sent address bits.
// [R5] data line only pulled low or released, never driven high.
// [R6] write-protect input high enables protection, low disables it.
// [R7] data falling while clock high is a start; every transaction opens so.
// [R8] data rising while clock high is a stop, ending the transaction.
// [R9] stop during a read abandons it and returns to standby.
// [R10] stop during a write ends data intake and launches the write cycle.
// [R11] data changes only while clock low; held stable in clock high.
// [R12] any data change during clock high is start or stop, not data.
// [R13] serial inputs processed on clock edges, not levels.
// [R14] eight-bit bytes; receiver pulls data low on the ninth clock.
// [R15] no acknowledge at all while the internal write cycle runs.
// [R16] memory left unmodified while write protection is active.
// [R17] address mismatch: line released, transaction ignored until next start.
// [R18] any start clears the counters so an address byte follows.
`timescale 1ns/1ps
module etwsf_front #(
    parameter logic [1:0] VARIANT    = etwsf_pkg::VAR_2K,
    parameter int         WR_CYCLES  = etwsf_pkg::WR_CYCLES_DEF,
    parameter int         FIFO_DEPTH = etwsf_pkg::FIFO_DEPTH_DEF
) (
    input  wire logic       SYS_CLK,
    input  wire logic       RST,
    input  wire logic       SCL,
    input  wire logic       SDA_IN,
    output logic            SDA_OUT,
    output logic            SDA_OE,
    input  wire logic       STRAP_ADDR_BIT0,
    input  wire logic       STRAP_ADDR_BIT1,
    input  wire logic       STRAP_ADDR_BIT2,
    input  wire logic       WP,
    output logic            WP_ACTIVE,
    output logic            SELECTED,
    output logic [7:0]      WDATA,
    output logic            WDATA_FIRST,
    output logic            WDATA_VALID,
    input  wire logic       WDATA_READY,
    input  wire logic [7:0] RD_DATA,
    output logic            RD_NEXT,
    output logic            WCYCLE_START,
    output logic            WCYCLE_BUSY
);
    localparam int FW = etwsf_pkg::FIFO_WIDTH_DEF;

    if (VARIANT > etwsf_pkg::VAR_8K || WR_CYCLES < 1 || WR_CYCLES >= (1 << etwsf_pkg::WR_CNT_W)
        || FIFO_DEPTH < 2) begin : g_bad_cfg
        $error("etwsf_front: unsupported parameter value");
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin sampling and edge detection

    logic [5:0] pins_s;
    logic       scl_s;
    logic       sda_s;
    logic       wp_s;
    logic [2:0] strap_s;
    logic       scl_d_r;
    logic       sda_d_r;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_det;
    logic       stop_det;

    etwsf_sync #(.WIDTH(6)) u_sync (
        .clk (SYS_CLK),
        .rst (RST),
        .d   ({SCL, SDA_IN, WP, STRAP_ADDR_BIT2, STRAP_ADDR_BIT1, STRAP_ADDR_BIT0}),
        .q   (pins_s)
    );

    assign scl_s   = pins_s[5];
    assign sda_s   = pins_s[4];
    assign wp_s    = pins_s[3];
    assign strap_s = pins_s[2:0];

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
        end
    end

    // scl must be high on both samples so a data edge next to a clock edge is not a condition
    assign scl_rise  = scl_s && !scl_d_r;                          // R13
    assign scl_fall  = !scl_s && scl_d_r;                          // R13
    assign start_det = scl_s && scl_d_r && sda_d_r && !sda_s;      // R7 R12
    assign stop_det  = scl_s && scl_d_r && !sda_d_r && sda_s;      // R8 R12

    ////////////////////////////////////////////////////////////////////////////
    // address compare

    function automatic logic addr_match(input logic [7:0] b, input logic [2:0] strap);
        addr_match = (b[7:4] == etwsf_pkg::DEV_CODE)
                  && (((b[3:1] ^ strap) & etwsf_pkg::strap_mask(VARIANT)) == 3'h0); // R1 R2 R3 R4
    endfunction : addr_match

    ////////////////////////////////////////////////////////////////////////////
    // byte engine

    etwsf_pkg::etwsf_state_t state_r;
    logic [etwsf_pkg::CNT_W-1:0] cnt_r;
    logic [7:0] sr_r;
    logic       oe_r;
    logic       rd_mode_r;
    logic       addr_byte_r;
    logic       first_r;
    logic       got_data_r;
    logic       push_r;
    logic [7:0] push_data_r;
    logic       push_first_r;
    logic       rd_next_r;
    logic       sel_r;
    logic       commit_r;
    logic       busy_r;
    logic       fifo_rdy;

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            state_r      <= etwsf_pkg::ST_IDLE;
            cnt_r        <= '0;
            sr_r         <= 8'h00;
            oe_r         <= 1'b0;
            rd_mode_r    <= 1'b0;
            addr_byte_r  <= 1'b0;
            first_r      <= 1'b0;
            got_data_r   <= 1'b0;
            push_r       <= 1'b0;
            push_data_r  <= 8'h00;
            push_first_r <= 1'b0;
            rd_next_r    <= 1'b0;
            sel_r        <= 1'b0;
            commit_r     <= 1'b0;
        end else begin
            push_r    <= 1'b0;
            rd_next_r <= 1'b0;
            commit_r  <= 1'b0;
            if (start_det) begin
                state_r     <= etwsf_pkg::ST_RECV;                   // R18
                cnt_r       <= '0;                                   // R18
                addr_byte_r <= 1'b1;                                 // R18
                oe_r        <= 1'b0;
                rd_mode_r   <= 1'b0;
                got_data_r  <= 1'b0;
                sel_r       <= 1'b0;
            end else if (stop_det) begin
                // an unprotected write sequence that delivered data launches the cycle; a read just ends
                commit_r   <= (state_r != etwsf_pkg::ST_IDLE) && !rd_mode_r && got_data_r && !wp_s; // R10 R16
                state_r    <= etwsf_pkg::ST_IDLE;                    // R9
                oe_r       <= 1'b0;
                sel_r      <= 1'b0;
                got_data_r <= 1'b0;
            end else begin
                unique case (state_r)
                    etwsf_pkg::ST_IDLE, etwsf_pkg::ST_IGNORE: begin
                    end
                    etwsf_pkg::ST_RECV: begin
                        if (scl_rise && cnt_r < etwsf_pkg::BYTE_BITS) begin
                            sr_r  <= {sr_r[6:0], sda_s};             // R11 R14
                            cnt_r <= cnt_r + 4'h1;
                        end else if (scl_fall && cnt_r == etwsf_pkg::BYTE_BITS) begin
                            if (addr_byte_r) begin
                                if (addr_match(sr_r, strap_s) && !busy_r) begin // R4 R15
                                    oe_r      <= 1'b1;               // R14
                                    state_r   <= etwsf_pkg::ST_ACK;
                                    rd_mode_r <= sr_r[0];
                                    sel_r     <= 1'b1;
                                    first_r   <= 1'b1;
                                end else begin
                                    state_r <= etwsf_pkg::ST_IGNORE; // R17
                                end
                            end else if (fifo_rdy) begin
                                // protected bytes are acknowledged but never reach the array
                                push_r       <= !wp_s;               // R16 R6
                                push_data_r  <= sr_r;
                                push_first_r <= first_r;
                                first_r      <= 1'b0;
                                got_data_r   <= 1'b1;
                                oe_r         <= 1'b1;                // R14
                                state_r      <= etwsf_pkg::ST_ACK;
                            end else begin
                                // full buffer refuses the byte by withholding the acknowledge
                                state_r <= etwsf_pkg::ST_IGNORE;
                            end
                        end
                    end
                    etwsf_pkg::ST_ACK: begin
                        if (scl_fall) begin
                            cnt_r       <= '0;
                            addr_byte_r <= 1'b0;
                            if (rd_mode_r) begin
                                sr_r    <= RD_DATA;
                                oe_r    <= !RD_DATA[7];              // R5
                                state_r <= etwsf_pkg::ST_SEND;
                            end else begin
                                oe_r    <= 1'b0;
                                state_r <= etwsf_pkg::ST_RECV;
                            end
                        end
                    end
                    etwsf_pkg::ST_SEND: begin
                        if (scl_fall) begin                          // R11
                            if (cnt_r == etwsf_pkg::LAST_TX) begin
                                oe_r      <= 1'b0;
                                rd_next_r <= 1'b1;
                                cnt_r     <= '0;
                                state_r   <= etwsf_pkg::ST_MACK;
                            end else begin
                                cnt_r <= cnt_r + 4'h1;
                                sr_r  <= {sr_r[6:0], 1'b0};
                                oe_r  <= !sr_r[6];                   // R5
                            end
                        end
                    end
                    etwsf_pkg::ST_MACK: begin
                        if (scl_rise && sda_s) begin
                            state_r <= etwsf_pkg::ST_IGNORE;         // R14
                        end else if (scl_fall) begin
                            sr_r    <= RD_DATA;
                            oe_r    <= !RD_DATA[7];
                            state_r <= etwsf_pkg::ST_SEND;
                        end
                    end
                    default: begin
                        state_r <= etwsf_pkg::ST_IDLE;
                        oe_r    <= 1'b0;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // internal write cycle timer

    logic [etwsf_pkg::WR_CNT_W-1:0] wr_cnt_r;

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            busy_r   <= 1'b0;
            wr_cnt_r <= '0;
        end else if (commit_r) begin
            busy_r   <= 1'b1;                                        // R10
            wr_cnt_r <= etwsf_pkg::WR_CNT_W'(WR_CYCLES - 1);
        end else if (busy_r) begin
            if (wr_cnt_r == '0) begin
                busy_r <= 1'b0;
            end else begin
                wr_cnt_r <= wr_cnt_r - 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // write data buffer and output registers

    etwsf_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk       (SYS_CLK),
        .rst       (RST),
        .in_valid  (push_r),
        .in_ready  (fifo_rdy),
        .in_data   ({push_first_r, push_data_r}),
        .out_valid (WDATA_VALID),
        .out_ready (WDATA_READY),
        .out_data  ({WDATA_FIRST, WDATA})
    );

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            WP_ACTIVE <= 1'b0;
        end else begin
            WP_ACTIVE <= wp_s;                                       // R6
        end
    end

    assign SDA_OUT      = 1'b0;                                      // R5
    assign SDA_OE       = oe_r;
    assign SELECTED     = sel_r;
    assign RD_NEXT      = rd_next_r;
    assign WCYCLE_START = commit_r;
    assign WCYCLE_BUSY  = busy_r;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    a_oe_on_edges: assert property (@(posedge SYS_CLK) disable iff (RST) // R11
        $changed(SDA_OE) |-> $past(scl_fall) || $past(start_det) || $past(stop_det))
        else $error("data line drive changed while clock high");

    a_start_clears_cnt: assert property (@(posedge SYS_CLK) disable iff (RST) // R18
        start_det |=> state_r == etwsf_pkg::ST_RECV && cnt_r == '0 && addr_byte_r)
        else $error("start did not restart address reception");

    a_stop_read_idle: assert property (@(posedge SYS_CLK) disable iff (RST) // R9
        stop_det && rd_mode_r |=> state_r == etwsf_pkg::ST_IDLE && !SDA_OE && !WCYCLE_START)
        else $error("stop in read did not return to standby");

    a_stop_write_cycle: assert property (@(posedge SYS_CLK) disable iff (RST) // R10
        stop_det && !rd_mode_r && got_data_r && !wp_s && state_r != etwsf_pkg::ST_IDLE
        |=> WCYCLE_START ##1 WCYCLE_BUSY [*3])
        else $error("stop in write did not launch the write cycle");

    a_busy_no_ack: assert property (@(posedge SYS_CLK) disable iff (RST) // R15
        busy_r && scl_fall && state_r == etwsf_pkg::ST_RECV && addr_byte_r && cnt_r == etwsf_pkg::BYTE_BITS
        |=> !SDA_OE && state_r == etwsf_pkg::ST_IGNORE)
        else $error("address acknowledged during write cycle");

    a_wp_no_push: assert property (@(posedge SYS_CLK) disable iff (RST) // R16
        $past(wp_s) && wp_s |-> !push_r && !WCYCLE_START)
        else $error("protected write reached the array");

    a_ignore_release: assert property (@(posedge SYS_CLK) disable iff (RST) // R17
        state_r == etwsf_pkg::ST_IGNORE && !start_det |=> (state_r == etwsf_pkg::ST_IGNORE
        || state_r == etwsf_pkg::ST_IDLE) && !SDA_OE)
        else $error("ignored transaction touched the data line");

    a_addr_ack_match: assert property (@(posedge SYS_CLK) disable iff (RST) // R4
        $rose(SDA_OE) && state_r == etwsf_pkg::ST_ACK && addr_byte_r |-> addr_match($past(sr_r), $past(strap_s)))
        else $error("acknowledged a foreign address");

endmodule : etwsf_front

// file: etwsf_master.sv
// two-wire bus master model standing on the far side of the front end
`timescale 1ns/1ps
module etwsf_master (
    input  wire logic clk,
    input  wire logic sda_wire,
    output logic      scl,
    output logic      sda_rel
);
    // bus idles released: clock high and data left to the pull-up
    initial begin
        scl     = 1'b1;
        sda_rel = 1'b1;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wait_clk

    // one clock: data set in the low phase, sampled mid high phase, ends low
    task automatic bit_io(input logic b, output logic seen);
        sda_rel = b;
        wait_clk(6);
        scl = 1'b1;
        wait_clk(6);
        seen = sda_wire;
        wait_clk(6);
        scl = 1'b0;
        wait_clk(7);
    endtask : bit_io

    task automatic start_cond();
        sda_rel = 1'b1;
        wait_clk(6);
        scl = 1'b1;
        wait_clk(6);
        sda_rel = 1'b0;
        wait_clk(6);
        scl = 1'b0;
        wait_clk(7);
    endtask : start_cond

    // leaves the bus idle with the clock standing high
    task automatic stop_cond();
        sda_rel = 1'b0;
        wait_clk(6);
        scl = 1'b1;
        wait_clk(6);
        sda_rel = 1'b1;
        wait_clk(6);
    endtask : stop_cond

    task automatic xfer(input logic [7:0] tx, input logic ninth_tx, output logic [7:0] rx, output logic ninth_rx);
        for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
        bit_io(ninth_tx, ninth_rx);
    endtask : xfer
endmodule : etwsf_master

// file: etwsf_pkg.sv
// shared constants and types for the two-wire eeprom slave front end
package etwsf_pkg;

    // memory density variants
    localparam logic [1:0] VAR_1K = 2'h0;
    localparam logic [1:0] VAR_2K = 2'h1;
    localparam logic [1:0] VAR_4K = 2'h2;
    localparam logic [1:0] VAR_8K = 2'h3;

    // strap compare masks, bit order {strap_addr_bit2, strap_addr_bit1, strap_addr_bit0}
    localparam logic [2:0] MASK_THREE = 3'h7;
    localparam logic [2:0] MASK_TWO   = 3'h6;
    localparam logic [2:0] MASK_ONE   = 3'h4;

    localparam logic [3:0] DEV_CODE   = 4'ha;
    localparam logic [3:0] BYTE_BITS  = 4'h8;
    localparam logic [3:0] LAST_TX    = 4'h7;
    localparam int         CNT_W      = 4;

    // internal write time
    localparam int T_WR_US        = 10000;
    localparam int CLK_MHZ        = 200;
    localparam int WR_CYCLES_DEF  = T_WR_US * CLK_MHZ;
    localparam int WR_CNT_W       = 22;

    localparam int FIFO_DEPTH_DEF = 4;
    localparam int FIFO_WIDTH_DEF = 9;

    typedef enum logic [5:0] {
        ST_IDLE   = 6'h01,
        ST_RECV   = 6'h02,
        ST_ACK    = 6'h04,
        ST_SEND   = 6'h08,
        ST_MACK   = 6'h10,
        ST_IGNORE = 6'h20
    } etwsf_state_t;

    function automatic logic [2:0] strap_mask(input logic [1:0] variant);
        unique case (variant)
            VAR_1K, VAR_2K: strap_mask = MASK_THREE;
            VAR_4K:         strap_mask = MASK_TWO;
            default:        strap_mask = MASK_ONE;
        endcase
    endfunction : strap_mask

endpackage : etwsf_pkg

// file: etwsf_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module etwsf_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_r;

    if (WIDTH < 1) begin : g_bad_width
        $error("etwsf_sync: WIDTH must be at least 1");
    end

    // meta_r feeds q only
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_r <= '0;
            q      <= '0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule : etwsf_sync

// file: etwsf_tb.sv
// self-checking bench: three density variants share one two-wire bus
`timescale 1ns/1ps
module testbench;
    localparam int         NV   = 3;
    localparam int         WRC  = 400;
    localparam logic [5:0] VARS = {etwsf_pkg::VAR_8K, etwsf_pkg::VAR_4K, etwsf_pkg::VAR_2K};
    localparam logic [23:0] CORN = {6'h3b, 6'h2d, 6'h02, 6'h01};

    logic          clk, rst, scl, sda_rel, sda_wire, wp, ready, hold_ready;
    logic [2:0]    strap;
    logic [7:0]    rd_data;
    logic [NV-1:0] oe, sel, wstart, busy, rdnext, sdaout, wpact, wfirst, wvalid;
    logic [7:0]    wdata [NV];
    logic [31:0]   lfsr, rnd;
    logic [8:0]    popq [$];
    int            errors, cmp_count, wstart_cnt, rdnext_cnt, busy_run, busy_len;

    etwsf_master m (.clk(clk), .sda_wire(sda_wire), .scl(scl), .sda_rel(sda_rel));
    // open-drain wire with pull-up: any pulling party wins
    assign sda_wire = sda_rel & ~(|oe);

    for (genvar i = 0; i < NV; i++) begin : g
        etwsf_front #(.VARIANT(VARS[2*i +: 2]), .WR_CYCLES(WRC)) dut (
            .SYS_CLK(clk), .RST(rst), .SCL(scl), .SDA_IN(sda_wire), .SDA_OUT(sdaout[i]), .SDA_OE(oe[i]),
            .STRAP_ADDR_BIT0(strap[0]), .STRAP_ADDR_BIT1(strap[1]), .STRAP_ADDR_BIT2(strap[2]),
            .WP(wp), .WP_ACTIVE(wpact[i]), .SELECTED(sel[i]), .WDATA(wdata[i]), .WDATA_FIRST(wfirst[i]),
            .WDATA_VALID(wvalid[i]), .WDATA_READY(ready), .RD_DATA(rd_data), .RD_NEXT(rdnext[i]),
            .WCYCLE_START(wstart[i]), .WCYCLE_BUSY(busy[i]));
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    function automatic logic exp_sel(input logic [1:0] v, input logic [2:0] s, input logic [2:0] a);
        logic [2:0] mk;
        mk = (v == etwsf_pkg::VAR_8K) ? 3'h4 : ((v == etwsf_pkg::VAR_4K) ? 3'h6 : 3'h7);
        return ((s ^ a) & mk) == 3'h0;
    endfunction : exp_sel

    task automatic chk(input string nm, input logic [8:0] exp, input logic [8:0] got);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic report_and_stop();
        $display("errors %0d comparisons %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : report_and_stop

    task automatic addr_phase(input logic [7:0] a, output logic acked);
        logic [7:0] rx;
        logic       n;
        m.start_cond();
        m.xfer(a, 1'b1, rx, n);
        acked = ~n;
    endtask : addr_phase

    task automatic wbyte(input logic [7:0] d, output logic acked);
        logic [7:0] rx;
        logic       n;
        m.xfer(d, 1'b1, rx, n);
        acked = ~n;
    endtask : wbyte

    // bounded wait for the write cycle to finish, then let the fifo drain
    task automatic wait_idle();
        int n;
        n = 0;
        while (busy[0] !== 1'b0 && n < 2000) begin
            m.wait_clk(1);
            n++;
        end
        m.wait_clk(60);
    endtask : wait_idle

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // random ready, and the memory side steps its byte on every advance pulse of the first front end
    always @(posedge clk) begin
        #1;
        lfsr = lfsr_next(lfsr);
        if (!hold_ready) ready = lfsr[0];
        if (rdnext[0] === 1'b1) rd_data = rd_data ^ 8'h5a;
    end

    always @(posedge clk) begin
        if (wvalid[0] === 1'b1 && ready === 1'b1) popq.push_back({wfirst[0], wdata[0]});
        wstart_cnt += $countones(wstart);
        rdnext_cnt += $countones(rdnext);
        busy_run = (busy[0] === 1'b1) ? busy_run + 1 : 0;
        if (busy[0] === 1'b1) busy_len = busy_run;
    end

    initial begin
        repeat (90000) @(posedge clk);
        errors++;
        report_and_stop();
    end

    initial begin
        logic [7:0] rx, d1, d2, r0;
        logic       n, ack;
        logic [2:0] s, a, ev;
        int         w0;
        rst = 1'b1; strap = 3'h0; wp = 1'b0; ready = 1'b0; hold_ready = 1'b0; rd_data = 8'h3c;
        lfsr = 32'h170c; rnd = 32'h170c;
        errors = 0; cmp_count = 0; wstart_cnt = 0; rdnext_cnt = 0; busy_run = 0; busy_len = 0;
        repeat (5) @(posedge clk);
        #1 rst = 1'b0;
        m.wait_clk(4);
        // strap compare per variant; corners first, then a wrong device code, then random
        for (int k = 0; k < 12; k++) begin
            rnd = lfsr_next(rnd);
            {s, a} = (k < 4) ? CORN[6*k +: 6] : rnd[5:0];
            strap = s;
            m.wait_clk(4);
            for (int i = 0; i < NV; i++) ev[i] = (k != 4) && exp_sel(VARS[2*i +: 2], s, a);
            addr_phase({(k == 4) ? ~etwsf_pkg::DEV_CODE : etwsf_pkg::DEV_CODE, a, 1'b0}, ack);
            chk("selected", {6'h0, ev}, {6'h0, sel});
            chk("address ack", {8'h0, |ev}, {8'h0, ack});
            m.stop_cond();
            chk("selected after stop", 9'h0, {6'h0, sel});
        end
        chk("write cycles", 9'h0, 9'(wstart_cnt));
        // aborted byte then repeated start, then a two-byte write and polling while busy
        strap = 3'h2;
        rnd = lfsr_next(rnd);
        d1 = rnd[7:0];
        d2 = rnd[15:8];
        m.wait_clk(4);
        m.start_cond();
        for (int i = 0; i < 4; i++) m.bit_io(i[0], n);
        addr_phase({etwsf_pkg::DEV_CODE, 3'h2, 1'b0}, ack);
        chk("ack after restart", 9'h1, {8'h0, ack});
        wbyte(8'h40, ack);
        chk("word ack", 9'h1, {8'h0, ack});
        wbyte(d1, ack);
        chk("data ack", 9'h1, {8'h0, ack});
        wbyte(d2, ack);
        m.stop_cond();
        addr_phase({etwsf_pkg::DEV_CODE, 3'h2, 1'b1}, ack);
        chk("ack while busy", 9'h0, {8'h0, ack});
        chk("write cycles", 9'h3, 9'(wstart_cnt));
        m.stop_cond();
        wait_idle();
        chk("busy length", 9'(WRC), 9'(busy_len));
        chk("pops", 9'h3, 9'(popq.size()));
        chk("word byte", {1'b1, 8'h40}, popq[0]);
        chk("data byte 1", {1'b0, d1}, popq[1]);
        chk("data byte 2", {1'b0, d2}, popq[2]);
        popq.delete();
        // mismatching address: every later byte ignored
        addr_phase({etwsf_pkg::DEV_CODE, 3'h6, 1'b0}, ack);
        chk("mismatch ack", 9'h0, {8'h0, ack});
        wbyte(8'h55, ack);
        chk("ignored byte ack", 9'h0, {8'h0, ack});
        m.stop_cond();
        m.wait_clk(20);
        chk("ignored pops", 9'h0, 9'(popq.size()));
        // two-byte read ended by master nack and stop
        rnd = lfsr_next(rnd);
        r0 = rnd[7:0];
        rd_data = r0;
        addr_phase({etwsf_pkg::DEV_CODE, 3'h2, 1'b1}, ack);
        chk("read address ack", 9'h1, {8'h0, ack});
        m.xfer(8'hff, 1'b0, rx, n);
        chk("read byte 1", {1'b0, r0}, {1'b0, rx});
        m.xfer(8'hff, 1'b1, rx, n);
        chk("read byte 2", {1'b0, r0 ^ 8'h5a}, {1'b0, rx});
        m.stop_cond();
        m.wait_clk(4);
        chk("selected after read stop", 9'h0, {6'h0, sel});
        chk("advance pulses", 9'h6, 9'(rdnext_cnt));
        chk("write cycles", 9'h3, 9'(wstart_cnt));
        chk("data out level", 9'h0, {6'h0, sdaout});
        // fifo filled with the far side stalled: fifth entry refused
        hold_ready = 1'b1;
        ready = 1'b0;
        addr_phase({etwsf_pkg::DEV_CODE, 3'h2, 1'b0}, ack);
        for (int b = 0; b < 5; b++) begin
            rnd = lfsr_next(rnd);
            wbyte(rnd[7:0], ack);
            chk("fill ack", {8'h0, b < 4}, {8'h0, ack});
        end
        m.stop_cond();
        hold_ready = 1'b0;
        wait_idle();
        chk("write cycles", 9'h6, 9'(wstart_cnt));
        chk("drained pops", 9'h4, 9'(popq.size()));
        popq.delete();
        // write protection: bytes acked, no write cycle, no data stored
        wp = 1'b1;
        m.wait_clk(4);
        chk("protect active", 9'h7, {6'h0, wpact});
        addr_phase({etwsf_pkg::DEV_CODE, 3'h2, 1'b0}, ack);
        wbyte(8'h10, ack);
        wbyte(8'ha5, ack);
        chk("protected ack", 9'h1, {8'h0, ack});
        m.stop_cond();
        m.wait_clk(60);
        w0 = popq.size();
        chk("protected write cycles", 9'h6, 9'(wstart_cnt));
        chk("protected pops", 9'h0, 9'(w0));
        wp = 1'b0;
        m.wait_clk(4);
        chk("protect inactive", 9'h0, {6'h0, wpact});
        report_and_stop();
    end
endmodule : testbench
